// ===== rtl/mcard_consts.svh
// constants for the memory card bus controller
// assumes a 20 MHz clk; included by the controller files
`ifndef MCARD_CONSTS_SVH
`define MCARD_CONSTS_SVH

// register byte offsets on the apb side
`define MC_REG_CTRL 8'h00
`define MC_REG_ADDR 8'h04
`define MC_REG_WDATA 8'h08
`define MC_REG_CMD 8'h0c
`define MC_REG_STATUS 8'h10

// field positions
`define MC_CTRL_BANK 0
`define MC_CTRL_SEG_LO 8
`define MC_CMD_READ 0
`define MC_CMD_WRITE 1
`define MC_ST_BUSY 0
`define MC_ST_DONE 1
`define MC_ST_RDATA_LO 8

// reset values
`define MC_BANK_RST 1'b0
`define MC_SEG_RST 8'hff

// timing, figures in ns and derived cycle counts
`define MC_CLK_NS 50
`define MC_ACCESS_NS 220
`define MC_BANKSET_NS 118
`define MC_SEGSET_NS 122
`define MC_CEIL_CYC(ns) (((ns) + `MC_CLK_NS - 1) / `MC_CLK_NS)
`define MC_ACCESS_CYC `MC_CEIL_CYC(`MC_ACCESS_NS)
`define MC_GUARD_CYC ((`MC_CEIL_CYC(`MC_BANKSET_NS) > \
   `MC_CEIL_CYC(`MC_SEGSET_NS)) ? `MC_CEIL_CYC(`MC_BANKSET_NS) : \
   `MC_CEIL_CYC(`MC_SEGSET_NS))
`define MC_SYNC_CYC 4
`define MC_STROBE_CYC (`MC_ACCESS_CYC + `MC_SYNC_CYC)

`endif

// ===== rtl/mcard_pkg.sv
// types shared by the memory card bus controller
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package mcard_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] addr_t;
   typedef logic [3:0] count_t;
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_STROBE = 4'b0100,
      ST_RECOVER = 4'b1000
   } cycle_e;
endpackage
`default_nettype wire

// ===== rtl/sync_if.sv
// carrier between the data pin synchroniser and the controller
// assumes one clock domain on the controller side
`default_nettype none
interface sync_if;
   logic [7:0] raw;
   logic [7:0] synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface
`default_nettype wire

// ===== rtl/pin_sync.sv
// three-stage synchroniser for the card data bus inputs
// assumes pins asynchronous to clk; output moves once stages agree
`default_nettype none
module pin_sync
(
   input wire logic clk,     // system clock
   input wire logic arst_n,  // async reset, active low
   sync_if.sync pins         // raw pins in, filtered value out
);
   logic [7:0] s1_r, s2_r, s3_r, out_r;
   logic [7:0] s1_nxt, s2_nxt, s3_nxt, out_nxt;

   always_comb
   begin
      s1_nxt = pins.raw;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      out_nxt = out_r;
      // stage one is never looked at except by stage two
      if (s2_r == s3_r)
      begin
         out_nxt = s3_r;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_r <= 8'h00;
         s2_r <= 8'h00;
         s3_r <= 8'h00;
         out_r <= 8'h00;
      end
      else
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         out_r <= out_nxt;
      end
   end

   assign pins.synced = out_r;
endmodule
`default_nettype wire

// ===== rtl/mcard_host.sv
// apb-controlled master for the byte-wide memory card backplane pins
// assumes the card strapped by jumpers; one clk at 20 MHz
// Function
// - two cards sharing a field need opposite bank polarities
// - bank line never floats; driven by another card or grounded
// - two-bank use: card enable forced, bank line to decoder input
// - each card gets its own segment select output bit
//
// Decided for this implementation: the APB slave port and the register addresses.
`include "mcard_consts.svh"
`default_nettype none
module mcard_host
(
   input wire logic clk,               // 20 MHz system clock
   input wire logic arst_n,            // async reset, active low
   input wire logic [7:0] paddr,       // apb address
   input wire logic psel,              // apb select
   input wire logic penable,           // apb enable
   input wire logic pwrite,            // apb direction
   input wire logic [31:0] pwdata,     // apb write data
   output logic [31:0] prdata,         // apb read data
   output logic pready,                // apb ready
   output logic pslverr,               // apb error, unmapped offset
   output mcard_pkg::addr_t addrOut,   // backplane address
   output mcard_pkg::byte_t dataOut,   // backplane data, driven side
   input wire mcard_pkg::byte_t dataIn, // backplane data, pin level
   output logic dataOe_n,              // data enable, low drives
   output logic memRq_n,               // memory request, low active
   output logic rd_n,                  // read strobe, low active
   output logic wr_n,                  // write strobe, low active
   output logic bankOut,               // bank line level
   output logic bankOe_n,              // bank enable, low drives
   output logic [7:0] segOut           // one segment select per card
);
   import mcard_pkg::*;

   sync_if dataSync ();
   assign dataSync.raw = dataIn;

   pin_sync u_sync
   (
      .clk(clk),
      .arst_n(arst_n),
      .pins(dataSync)
   );

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `MC_REG_CTRL) || (a == `MC_REG_ADDR) ||
         (a == `MC_REG_WDATA) || (a == `MC_REG_CMD) ||
         (a == `MC_REG_STATUS);
   endfunction

   // register and apb group
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic bank_r, bank_nxt;
   logic [7:0] seg_r, seg_nxt;
   addr_t addr_r, addr_nxt;
   byte_t wdata_r, wdata_nxt;
   logic bankOe_n_r;
   // cycle group
   cycle_e state_r, state_nxt;
   count_t cnt_r, cnt_nxt, guard_r, guard_nxt;
   addr_t addrOut_r, addrOut_nxt;
   byte_t dataOut_r, dataOut_nxt, rdata_r, rdata_nxt;
   logic dataOe_n_r, dataOe_n_nxt, memRq_n_r, memRq_n_nxt;
   logic rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
   logic isWr_r, isWr_nxt, done_r, done_nxt;
   // apb decode
   logic busy, wrAcc, wrOk, startRd, startWr, clrDone, linkChange;

   assign busy = (state_r != ST_IDLE);
   assign wrAcc = psel && penable && pready_r && pwrite;
   // while a cycle runs, configuration writes are refused
   assign wrOk = wrAcc && !busy && !pslverr_r;
   assign startRd = wrOk && (paddr == `MC_REG_CMD) &&
      pwdata[`MC_CMD_READ];
   assign startWr = wrOk && (paddr == `MC_REG_CMD) &&
      !pwdata[`MC_CMD_READ] && pwdata[`MC_CMD_WRITE];
   assign clrDone = wrAcc && (paddr == `MC_REG_STATUS) &&
      pwdata[`MC_ST_DONE];
   assign linkChange = wrOk && (paddr == `MC_REG_CTRL);

   always_comb
   begin
      prdata_nxt = prdata_r;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      bank_nxt = bank_r;
      seg_nxt = seg_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      if (psel && !penable)
      begin
         pready_nxt = 1'b1;
         pslverr_nxt = !mapped(paddr);
         prdata_nxt = 32'h0000_0000;
         unique case (paddr)
            `MC_REG_CTRL:
               begin
                  prdata_nxt[`MC_CTRL_BANK] = bank_r;
                  prdata_nxt[`MC_CTRL_SEG_LO +: 8] = seg_r;
               end
            `MC_REG_ADDR: prdata_nxt[15:0] = addr_r;
            `MC_REG_WDATA: prdata_nxt[7:0] = wdata_r;
            `MC_REG_STATUS:
               begin
                  prdata_nxt[`MC_ST_BUSY] = busy;
                  prdata_nxt[`MC_ST_DONE] = done_r;
                  prdata_nxt[`MC_ST_RDATA_LO +: 8] = rdata_r;
               end
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
      if (linkChange)
      begin
         // one bank level for all cards, chosen by software
         bank_nxt = pwdata[`MC_CTRL_BANK];
         // one bit per card, eight cards per register
         seg_nxt = pwdata[`MC_CTRL_SEG_LO +: 8];
      end
      if (wrOk && (paddr == `MC_REG_ADDR))
      begin
         addr_nxt = pwdata[15:0];
      end
      if (wrOk && (paddr == `MC_REG_WDATA))
      begin
         wdata_nxt = pwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         bank_r <= `MC_BANK_RST;
         seg_r <= `MC_SEG_RST;
         addr_r <= 16'h0000;
         wdata_r <= 8'h00;
         bankOe_n_r <= 1'b0;  // bank line driven from reset on
      end
      else
      begin
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         bank_r <= bank_nxt;
         seg_r <= seg_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         bankOe_n_r <= 1'b0;  // never released, so it never floats
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      guard_nxt = guard_r;
      addrOut_nxt = addrOut_r;
      dataOut_nxt = dataOut_r;
      rdata_nxt = rdata_r;
      dataOe_n_nxt = dataOe_n_r;
      memRq_n_nxt = memRq_n_r;
      rd_n_nxt = rd_n_r;
      wr_n_nxt = wr_n_r;
      isWr_nxt = isWr_r;
      done_nxt = done_r && !clrDone;
      // bank or segment change needs settling before a request
      if (linkChange)
      begin
         guard_nxt = count_t'(`MC_GUARD_CYC);
      end
      else if (guard_r != 4'h0)
      begin
         guard_nxt = guard_r - 4'h1;
      end
      unique case (state_r)
         ST_IDLE:
            if (startRd || startWr)
            begin
               addrOut_nxt = addr_r;
               isWr_nxt = startWr;
               dataOut_nxt = wdata_r;
               dataOe_n_nxt = !startWr;
               state_nxt = ST_SETUP;
            end
         ST_SETUP:
            // strobes wait out bank and segment settling
            if (guard_r == 4'h0)
            begin
               memRq_n_nxt = 1'b0;
               rd_n_nxt = isWr_r;
               wr_n_nxt = !isWr_r;
               cnt_nxt = count_t'(`MC_STROBE_CYC - 1);
               state_nxt = ST_STROBE;
            end
         ST_STROBE:
            if (cnt_r == 4'h0)
            begin
               // covers access time plus synchroniser lag
               if (!isWr_r)
               begin
                  rdata_nxt = dataSync.synced;
               end
               memRq_n_nxt = 1'b1;
               rd_n_nxt = 1'b1;
               wr_n_nxt = 1'b1;
               done_nxt = 1'b1;  // set wins over a same-cycle clear
               state_nxt = ST_RECOVER;
            end
            else
            begin
               cnt_nxt = cnt_r - 4'h1;
            end
         ST_RECOVER:
            begin
               // data held one cycle past the write strobe
               dataOe_n_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         guard_r <= 4'h0;
         addrOut_r <= 16'h0000;
         dataOut_r <= 8'h00;
         rdata_r <= 8'h00;
         dataOe_n_r <= 1'b1;
         memRq_n_r <= 1'b1;
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         isWr_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         guard_r <= guard_nxt;
         addrOut_r <= addrOut_nxt;
         dataOut_r <= dataOut_nxt;
         rdata_r <= rdata_nxt;
         dataOe_n_r <= dataOe_n_nxt;
         memRq_n_r <= memRq_n_nxt;
         rd_n_r <= rd_n_nxt;
         wr_n_r <= wr_n_nxt;
         isWr_r <= isWr_nxt;
         done_r <= done_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign addrOut = addrOut_r;
   assign dataOut = dataOut_r;
   assign dataOe_n = dataOe_n_r;
   assign memRq_n = memRq_n_r;
   assign rd_n = rd_n_r;
   assign wr_n = wr_n_r;
   assign bankOut = bank_r;
   assign bankOe_n = bankOe_n_r;
   assign segOut = seg_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence strobeLow;
      !memRq_n [*8] ##1 !memRq_n;
   endsequence

   bank_steady_a: assert property (!memRq_n |-> $stable(bankOut))
      else $error("bank line moved during a request");
   bank_driven_a: assert property (bankOe_n == 1'b0)
      else $error("bank line released");
   bank_settled_a: assert property
      ($fell(memRq_n) |-> $past(bankOut, 1) == bankOut &&
       $past(bankOut, 2) == bankOut && $past(bankOut, 3) == bankOut)
      else $error("request too soon after bank change");
   seg_steady_a: assert property (!memRq_n |-> $stable(segOut))
      else $error("segment select moved during a request");
   strobe_len_a: assert property
      ($fell(memRq_n) |-> strobeLow ##1 memRq_n)
      else $error("strobe length wrong");
   strobe_excl_a: assert property
      (!(rd_n == 1'b0 && wr_n == 1'b0) && (rd_n && wr_n || !memRq_n))
      else $error("strobes overlap or lack request");
   write_data_a: assert property
      (!wr_n |-> !dataOe_n ##1 (!dataOe_n || memRq_n))
      else $error("write without driven data");
   apb_ready_a: assert property
      (psel && !penable |=> pready ##1 !pready)
      else $error("apb answer not after one cycle");
endmodule
`default_nettype wire

// ===== tb/card_model.sv
// behavioural memory card: jumpered decode, bank and segment enables
// assumes strobes from the controller; all-2K map or dual 32K banks
`default_nettype none
module card_model
(
   input wire logic [15:0] addr,   // backplane address
   input wire logic [7:0] pins,    // resolved data bus level
   input wire logic memRq_n,       // memory request
   input wire logic rd_n,          // read strobe
   input wire logic wr_n,          // write strobe
   input wire logic bank,          // bank line level
   input wire logic seg,           // this card's segment line
   input wire logic bankGndSel,    // bank enable tied on
   input wire logic bankPolSel,    // enable on bank high
   input wire logic segPolSel,     // enable on segment low
   input wire logic twoBank,       // bank line into decoder option
   input wire logic [7:0] sockOff, // per-socket disable
   output logic [7:0] cardData,    // data driven on reads
   output logic cardOe,            // card drives the bus
   output int hits                 // selected strobes seen
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   logic [15:0] idx;
   logic [15:0] wIdx;
   logic [2:0] sock;
   logic inRange;
   logic sel;
   logic wSel;
   initial
   begin
      hits = 0;
      wSel = 1'b0;
   end
   always @*
   begin
      if (twoBank)
      begin
         inRange = addr[15];
         sock = {bank, addr[14:13]};
         idx = {bank, addr[14:0]};
      end
      else
      begin
         inRange = addr[15:14] == 2'h0;
         sock = addr[13:11];
         idx = {2'h0, addr[13:0]};
      end
      sel = !memRq_n && !(rd_n && wr_n) && inRange
         && !sockOff[sock]
         && (bankGndSel || bank == bankPolSel)
         && (seg != segPolSel);
      cardOe = sel && !rd_n;
      cardData = mem[idx];
   end
   // latch the target while strobed; address and data outlive the strobe
   always @*
      if (!wr_n && !memRq_n)
      begin
         wSel = sel;
         wIdx = idx;
      end
   always @(posedge wr_n)
      if (wSel)
         mem[wIdx] = pins;
   always @(posedge sel)
      hits++;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench: apb master, card model, pin resolution
// assumes the controller drives one card on segment bit 0
`include "mcard_consts.svh"
`default_nettype none
module testbench;
   import mcard_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, arst_n, psel, penable, pwrite, pslverr, pready;
   logic dataOe_n, memRq_n, rd_n, wr_n, bankOut, bankOe_n, cardOe;
   logic bankGndSel, bankPolSel, segPolSel, twoBank;
   logic [7:0] paddr, segOut, sockOff, cardData, floatPat;
   logic [31:0] pwdata, prdata;
   addr_t addrOut;
   byte_t dataOut, dataIn;
   int hits, miscompares, cmpCount, cyc, lowCnt, lowLen;
   // released bus shows a moving pattern, never the last value
   assign dataIn = !dataOe_n ? dataOut : cardOe ? cardData : floatPat;
   mcard_host dut (.clk(clk), .arst_n(arst_n), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .addrOut(addrOut), .dataOut(dataOut), .dataIn(dataIn),
      .dataOe_n(dataOe_n), .memRq_n(memRq_n), .rd_n(rd_n), .wr_n(wr_n),
      .bankOut(bankOut), .bankOe_n(bankOe_n), .segOut(segOut));
   card_model card (.addr(addrOut), .pins(dataIn), .memRq_n(memRq_n),
      .rd_n(rd_n), .wr_n(wr_n), .bank(bankOe_n ? floatPat[0] : bankOut),
      .seg(segOut[0]), .bankGndSel(bankGndSel), .bankPolSel(bankPolSel),
      .segPolSel(segPolSel), .twoBank(twoBank), .sockOff(sockOff),
      .cardData(cardData), .cardOe(cardOe), .hits(hits));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      floatPat <= ~floatPat;
      cyc <= cyc + 1;
      if (!memRq_n)
         lowCnt <= lowCnt + 1;
      else if (lowCnt != 0)
      begin
         lowLen <= lowCnt;
         lowCnt <= 0;
      end
      if (cyc == 30000)
      begin
         miscompares++;
         end_sim;
      end
   end
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(a, 1'b1, d, q, e);
   endtask
   task automatic ctrl(input logic [7:0] s, input logic b);
      wr(`MC_REG_CTRL, {16'h0, s, 7'h0, b});
   endtask
   // one backplane cycle; judges selection and strobe length
   task automatic acc(input addr_t a, input logic w, input byte_t d,
      input logic hit, output byte_t r);
      logic [31:0] q;
      logic e;
      int h0;
      h0 = hits;
      wr(`MC_REG_ADDR, {16'h0, a});
      wr(`MC_REG_WDATA, {24'h0, d});
      wr(`MC_REG_CMD, {30'h0, w, !w});
      do
         apb(`MC_REG_STATUS, 1'b0, 32'h0, q, e);
      while (q[1] !== 1'b1);
      wr(`MC_REG_STATUS, 32'h2);
      r = q[15:8];
      check(hits - h0, {31'h0, hit});
      check(lowLen, `MC_STROBE_CYC);
   endtask
   task automatic t_reset;
      logic [31:0] q;
      logic e;
      check({memRq_n, rd_n, wr_n, dataOe_n}, 32'hf);
      check({bankOe_n, bankOut}, 32'h0);
      check(segOut, 32'hff);
      apb(8'h14, 1'b0, 32'h0, q, e);
      check({q[30:0], e}, 32'h1);
   endtask
   task automatic t_sockets;
      byte_t r;
      for (int s = 0; s < 8; s++)
         acc({2'h0, s[2:0], 11'h7ff}, 1'b1, 8'h10 + s[7:0], 1'b1,
            r);
      for (int s = 0; s < 8; s++)
      begin
         sockOff <= 8'h1 << s;
         acc({2'h0, s[2:0], 11'h7ff}, 1'b0, 8'h0, 1'b0, r);
         acc({2'h0, s[2:0] + 3'h1, 11'h7ff}, 1'b0, 8'h0, 1'b1, r);
         check(r, 8'h10 + ((s + 1) % 8));
      end
      sockOff <= 8'h0;
      acc(16'h4000, 1'b1, 8'h99, 1'b0, r);
   endtask
   task automatic t_bank;
      byte_t r;
      ctrl(8'hff, 1'b1);
      acc(16'h0010, 1'b1, 8'h11, 1'b0, r);
      bankPolSel <= 1'b1;
      acc(16'h0010, 1'b1, 8'h77, 1'b1, r);
      ctrl(8'hff, 1'b0);
      acc(16'h0010, 1'b0, 8'h0, 1'b0, r);
      bankGndSel <= 1'b1;
      acc(16'h0010, 1'b0, 8'h0, 1'b1, r);
      check(r, 8'h77);
      bankGndSel <= 1'b0;
      bankPolSel <= 1'b0;
   endtask
   task automatic t_seg;
      byte_t r;
      ctrl(8'hfe, 1'b0);
      acc(16'h0010, 1'b0, 8'h0, 1'b0, r);
      segPolSel <= 1'b1;
      acc(16'h0010, 1'b0, 8'h0, 1'b1, r);
      check(r, 8'h77);
      ctrl(8'hff, 1'b0);
      acc(16'h0010, 1'b0, 8'h0, 1'b0, r);
      segPolSel <= 1'b0;
   endtask
   // config writes during a cycle are dropped; read wins over write
   task automatic t_refuse;
      logic [31:0] q;
      logic e;
      byte_t r;
      wr(`MC_REG_ADDR, 32'h0000_0010);
      wr(`MC_REG_CMD, 32'h0000_0003);
      wr(`MC_REG_CTRL, 32'h0000_0001);
      apb(`MC_REG_CTRL, 1'b0, 32'h0, q, e);
      check(q, 32'h0000_ff00);
      do
         apb(`MC_REG_STATUS, 1'b0, 32'h0, q, e);
      while (q[1] !== 1'b1);
      wr(`MC_REG_STATUS, 32'h2);
      acc(16'h0010, 1'b0, 8'h0, 1'b1, r);
      check(r, 8'h77);
   endtask
   task automatic t_two;
      byte_t r;
      twoBank <= 1'b1;
      bankGndSel <= 1'b1;
      acc(16'h8000, 1'b1, 8'ha5, 1'b1, r);
      ctrl(8'hff, 1'b1);
      acc(16'h8000, 1'b1, 8'h5a, 1'b1, r);
      acc(16'h0010, 1'b0, 8'h0, 1'b0, r);
      acc(16'h8000, 1'b0, 8'h0, 1'b1, r);
      check(r, 8'h5a);
      ctrl(8'hff, 1'b0);
      acc(16'h8000, 1'b0, 8'h0, 1'b1, r);
      check(r, 8'ha5);
      sockOff <= 8'h01;
      acc(16'h8000, 1'b0, 8'h0, 1'b0, r);
   endtask
   initial
   begin
      arst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {bankGndSel, bankPolSel, segPolSel, twoBank, sockOff} = '0;
      {miscompares, cmpCount, cyc, lowCnt, lowLen} = '0;
      floatPat = 8'h5a;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_sockets;
      t_bank;
      t_seg;
      t_refuse;
      t_two;
      end_sim;
   end
endmodule
`default_nettype wire
